// ==== logic/panel_mode_pkg.sv ====
// Constants and types shared by the panel mode and control logic.
// Assumes one 40 MHz system clock; all pins arrive asynchronously.
package panel_mode_pkg;

    // ************************************************************
    // Geometry and timing
    // ************************************************************
    localparam int COLUMN_COUNT = 1920;
    localparam int LINE_COUNT = 720;
    localparam int RELOAD_FRAMES = 60;
    localparam int SYS_CLK_HZ = 40_000_000;

    // ************************************************************
    // Pin vector positions
    // ************************************************************
    localparam int PIN_HDIR = 0;
    localparam int PIN_VDIR = 1;
    localparam int PIN_BIST = 2;
    localparam int PIN_CSEL = 3;
    localparam int PIN_ARLD = 4;
    localparam int PIN_INV = 5;
    localparam int PIN_RSTN = 6;
    localparam int PIN_STBYN = 7;
    localparam int PIN_SCL = 8;
    localparam int PIN_SDA = 9;
    localparam int PIN_COUNT = 10;
    // Idle levels of the pins, loaded into synchronisers at reset
    localparam logic [PIN_COUNT-1:0] PIN_RESET_VAL = 10'h3FB;

    // ************************************************************
    // Serial register map
    // ************************************************************
    localparam logic [6:0] REG_CTRL = 7'h00;
    localparam logic [6:0] REG_STATUS = 7'h01;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;

    // Function settings, field order fixes the CTRL register bits
    typedef struct packed {
        logic auto_reload;   // bit 4
        logic dot_inversion; // bit 3: 1 dot, 0 one-plus-two dot
        logic self_test;     // bit 2
        logic vdir_fwd;      // bit 1: 1 top to bottom
        logic hdir_fwd;      // bit 0: 1 first column to last
    } settings_t;

    localparam settings_t SETTINGS_RESET = 5'h1B;

    // Serial write strobe with its payload
    typedef struct packed {
        logic       wr;
        logic [6:0] addr;
        logic [7:0] data;
    } cfg_write_t;

    // Serial port states, one-hot
    typedef enum logic [4:0] {
        SP_IDLE  = 5'h01,
        SP_ADDR  = 5'h02,
        SP_ACK   = 5'h04,
        SP_WDATA = 5'h08,
        SP_RDATA = 5'h10
    } serial_state_t;

    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

endpackage

// ==== logic/serial_cfg_port.sv ====
// Two-wire serial configuration slave: register address then data.
// Assumes scl and sda already synchronised to sys_clk_i.
`timescale 1ns/1ps
`default_nettype none

module serial_cfg_port
    import panel_mode_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic clr_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic [7:0] rd_data_i,
    output logic [6:0] rd_addr_o,
    output cfg_write_t wr_o,
    output logic sda_oe_o
);

    typedef struct packed {
        serial_state_t st;
        logic [3:0]    cnt;
        logic [7:0]    sh;
        logic [6:0]    addr;
        logic          rd;
        logic          data_phase;
        logic          oe;
        logic          scl_q;
        logic          sda_q;
        cfg_write_t    w;
    } sp_state_t;

    localparam sp_state_t SP_RESET = '{st: SP_IDLE, scl_q: 1'b1, sda_q: 1'b1, default: '0};

    sp_state_t r;
    sp_state_t n;
    logic rise;
    logic fall;
    logic start;
    logic stop;

    // ************************************************************
    // Bus conditions and byte sequencing
    // ************************************************************
    always_comb begin
        n = r;
        n.scl_q = scl_i;
        n.sda_q = sda_i;
        n.w.wr = 1'b0;
        rise = ~r.scl_q & scl_i;
        fall = r.scl_q & ~scl_i;
        start = r.scl_q & scl_i & r.sda_q & ~sda_i;
        stop = r.scl_q & scl_i & ~r.sda_q & sda_i;
        if (clr_i || stop) begin
            n.st = SP_IDLE;
            n.oe = 1'b0;
        end else if (start) begin
            n.st = SP_ADDR;
            n.cnt = 4'h0;
            n.oe = 1'b0;
            n.data_phase = 1'b0;
        end else begin
            case (r.st)
                SP_ADDR, SP_WDATA: begin
                    if (rise) begin
                        n.sh = {r.sh[6:0], sda_i};
                        n.cnt = r.cnt + 4'h1;
                    end else if (fall && r.cnt == BITS_PER_BYTE) begin
                        n.st = SP_ACK;
                        n.oe = 1'b1; // Acknowledge by pulling low
                        if (r.st == SP_ADDR) begin
                            n.addr = r.sh[7:1];
                            n.rd = r.sh[0];
                        end else begin
                            n.w = '{wr: 1'b1, addr: r.addr, data: r.sh};
                            n.data_phase = 1'b1;
                        end
                    end
                end
                SP_ACK: begin
                    if (fall) begin
                        n.cnt = 4'h0;
                        n.oe = 1'b0;
                        if (r.data_phase) begin
                            n.st = SP_IDLE;
                        end else if (r.rd) begin
                            n.st = SP_RDATA;
                            n.sh = rd_data_i;
                            n.oe = ~rd_data_i[7];
                        end else begin
                            n.st = SP_WDATA;
                        end
                    end
                end
                SP_RDATA: begin
                    if (rise) begin
                        n.cnt = r.cnt + 4'h1;
                    end else if (fall) begin
                        if (r.cnt == BITS_PER_BYTE) begin
                            n.st = SP_IDLE; // Master acknowledge ignored
                            n.oe = 1'b0;
                        end else begin
                            n.sh = {r.sh[6:0], 1'b0};
                            n.oe = ~r.sh[6];
                        end
                    end
                end
                SP_IDLE: begin
                    n.oe = 1'b0;
                end
                default: begin
                    n.st = SP_IDLE;
                    n.oe = 1'b0;
                end
            endcase
        end
    end

    // State register, frozen while ce_i is low
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            r <= SP_RESET;
        end else if (ce_i) begin
            r <= n;
        end
    end

    assign rd_addr_o = r.addr;
    assign wr_o = r.w;
    assign sda_oe_o = r.oe;

endmodule // serial_cfg_port

`default_nettype wire

// ==== logic/panel_mode_ctrl.sv ====
// Mode and control-pin logic of a dual-link display driver board.
// Assumes strap pins are asynchronous and the frame, line and column
// strobes come from timing logic on sys_clk_i.
//
// Notes on behaviour
// - High horizontal direction walks columns 1 to 1920, low walks back.
// - High vertical direction scans lines top to bottom, low bottom to top.
// - Self-test enable high selects self-test mode; host ties it low otherwise.
// - Source select high takes settings from pins, low from registers.
// - Auto-reload high reloads stored settings every 60 frames; low disables.
// - Inversion select high gives dot inversion, low one-plus-two dot.
// - Active-low global reset returns settings, scan counters, fault and power to initial state while low; synchronisers keep sampling.
// - Active-low standby turns off timing, buffers, converters and power.
// - Two-wire port; host clocks, data line carries address and data.
// - Each board drives a fault output wired together with the others.
`timescale 1ns/1ps
`default_nettype none

module panel_mode_ctrl
    import panel_mode_pkg::*;
#(
    parameter int COLUMNS = COLUMN_COUNT,
    parameter int LINES = LINE_COUNT,
    parameter int FRAMES_PER_RELOAD = RELOAD_FRAMES
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic horizontal_scan_dir_i,
    input wire logic vertical_scan_dir_i,
    input wire logic self_test_en_i,
    input wire logic config_source_select_i,
    input wire logic nvm_auto_reload_en_i,
    input wire logic polarity_inversion_sel_i,
    input wire logic global_reset_n_i,
    input wire logic standby_n_i,
    input wire logic serial_clk_i,
    input wire logic serial_data_i,
    input wire logic frame_start_i,
    input wire logic line_start_i,
    input wire logic column_step_i,
    input wire logic fault_i,
    output logic serial_data_o,
    output logic serial_data_oe_o,
    output logic [$clog2(COLUMNS+1)-1:0] source_column_output_o,
    output logic [$clog2(LINES+1)-1:0] gate_line_o,
    output settings_t active_settings_o,
    output logic nvm_reload_o,
    output logic timing_ctrl_en_o,
    output logic output_buffer_en_o,
    output logic dac_en_o,
    output logic power_circuit_en_o,
    output logic fault_detect_out_o,
    output logic fault_detect_out_oe_o
);

    localparam int COL_W = $clog2(COLUMNS + 1);
    localparam int LINE_W = $clog2(LINES + 1);
    localparam int FRM_W = $clog2(FRAMES_PER_RELOAD);
    localparam logic [COL_W-1:0] COL_LAST = COL_W'(COLUMNS);
    localparam logic [COL_W-1:0] COL_ONE = COL_W'(1);
    localparam logic [LINE_W-1:0] LINE_LAST = LINE_W'(LINES);
    localparam logic [LINE_W-1:0] LINE_ONE = LINE_W'(1);
    localparam logic [FRM_W-1:0] FRM_LAST = FRM_W'(FRAMES_PER_RELOAD - 1);

    // ************************************************************
    // Parameter checks
    // ************************************************************
    if (COLUMNS < 2 || LINES < 2 || FRAMES_PER_RELOAD < 2) begin : g_bad_param
        $error("panel_mode_ctrl: counts must be at least 2");
    end

    typedef struct packed {
        logic [PIN_COUNT-1:0] s1;
        logic [PIN_COUNT-1:0] s2;
        logic [PIN_COUNT-1:0] s3;
        logic [PIN_COUNT-1:0] filt;
        settings_t            cfg;
        settings_t            live;
        logic [COL_W-1:0]     col;
        logic [LINE_W-1:0]    line;
        logic [FRM_W-1:0]     frames;
        logic                 reload;
        logic                 power;
        logic                 fault;
    } ctrl_state_t;

    localparam ctrl_state_t CTRL_RESET = '{
        s1: PIN_RESET_VAL, s2: PIN_RESET_VAL, s3: PIN_RESET_VAL, filt: PIN_RESET_VAL,
        cfg: SETTINGS_RESET, live: SETTINGS_RESET, col: COL_ONE, line: LINE_ONE,
        default: '0};

    ctrl_state_t r;
    ctrl_state_t n;
    logic [PIN_COUNT-1:0] pins;
    logic greset;
    settings_t pin_set;
    settings_t chosen;
    cfg_write_t wr;
    logic [6:0] rd_addr;
    logic [7:0] rd_data;

    assign pins = {serial_data_i, serial_clk_i, standby_n_i, global_reset_n_i,
                   polarity_inversion_sel_i, nvm_auto_reload_en_i, config_source_select_i,
                   self_test_en_i, vertical_scan_dir_i, horizontal_scan_dir_i};

    // ************************************************************
    // Serial configuration port
    // ************************************************************
    serial_cfg_port u_serial (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .clr_i(greset),
        .scl_i(r.filt[PIN_SCL]),
        .sda_i(r.filt[PIN_SDA]),
        .rd_data_i(rd_data),
        .rd_addr_o(rd_addr),
        .wr_o(wr),
        .sda_oe_o(serial_data_oe_o)
    );

    // Read data for the serial port
    always_comb begin
        case (rd_addr)
            REG_CTRL: rd_data = {3'h0, r.cfg};
            REG_STATUS: rd_data = {r.fault, r.power, r.filt[PIN_CSEL], r.live};
            default: rd_data = RD_UNMAPPED;
        endcase
    end

    // ************************************************************
    // Synchronisers, settings and scan counters
    // ************************************************************
    always_comb begin
        n = r;
        // Three stages, accept once second and third agree
        n.s1 = pins;
        n.s2 = r.s1;
        n.s3 = r.s2;
        n.filt = (r.s2 & r.s3) | (r.filt & (r.s2 ^ r.s3));
        greset = ~r.filt[PIN_RSTN];
        pin_set = '{auto_reload: r.filt[PIN_ARLD], dot_inversion: r.filt[PIN_INV],
                    self_test: r.filt[PIN_BIST], vdir_fwd: r.filt[PIN_VDIR],
                    hdir_fwd: r.filt[PIN_HDIR]};
        chosen = r.filt[PIN_CSEL] ? pin_set : r.cfg;
        n.reload = 1'b0;
        n.power = r.filt[PIN_STBYN] & ~greset;
        if (greset) begin
            // Hold every function at its initial state
            n.cfg = SETTINGS_RESET;
            n.live = SETTINGS_RESET;
            n.col = COL_ONE;
            n.line = LINE_ONE;
            n.frames = '0;
            n.fault = 1'b0;
        end else begin
            if (wr.wr && wr.addr == REG_CTRL) begin
                n.cfg = settings_t'(wr.data[4:0]);
            end
            n.fault = fault_i;
            if (frame_start_i) begin
                // Settings only change between frames
                n.live = chosen;
                n.col = chosen.hdir_fwd ? COL_ONE : COL_LAST;
                n.line = chosen.vdir_fwd ? LINE_ONE : LINE_LAST;
                // Periodic reload of stored settings
                if (!chosen.auto_reload) begin
                    n.frames = '0;
                end else if (r.frames == FRM_LAST) begin
                    n.frames = '0;
                    n.reload = 1'b1;
                end else begin
                    n.frames = r.frames + FRM_W'(1);
                end
            end else begin
                // Column walk direction
                if (line_start_i) begin
                    n.col = r.live.hdir_fwd ? COL_ONE : COL_LAST;
                end else if (column_step_i) begin
                    if (r.live.hdir_fwd && r.col != COL_LAST) begin
                        n.col = r.col + COL_ONE;
                    end else if (!r.live.hdir_fwd && r.col != COL_ONE) begin
                        n.col = r.col - COL_ONE;
                    end
                end
                // Gate line direction
                if (line_start_i && r.col != (r.live.hdir_fwd ? COL_ONE : COL_LAST)) begin
                    if (r.live.vdir_fwd && r.line != LINE_LAST) begin
                        n.line = r.line + LINE_ONE;
                    end else if (!r.live.vdir_fwd && r.line != LINE_ONE) begin
                        n.line = r.line - LINE_ONE;
                    end
                end
            end
        end
    end

    // State register, frozen while ce_i is low
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            r <= CTRL_RESET;
        end else if (ce_i) begin
            r <= n;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign serial_data_o = 1'b0;
    assign source_column_output_o = r.col;
    assign gate_line_o = r.line;
    assign active_settings_o = r.live;
    assign nvm_reload_o = r.reload;
    // Standby gates every analog and timing block
    assign timing_ctrl_en_o = r.power;
    assign output_buffer_en_o = r.power;
    assign dac_en_o = r.power;
    assign power_circuit_en_o = r.power;
    // Open-drain fault line, pulled low on fault
    assign fault_detect_out_o = 1'b0;
    assign fault_detect_out_oe_o = r.fault;

endmodule // panel_mode_ctrl

`default_nettype wire

// ==== verif/panel_mode_monitor.sv ====
// Port checks for the panel mode control top.
// Bound into each instance; straps are slow, strobes last one cycle.
`timescale 1ns/1ps
`default_nettype none
module panel_mode_monitor
    import panel_mode_pkg::*;
#(
    parameter int COLUMNS = COLUMN_COUNT,
    parameter int LINES = LINE_COUNT,
    parameter int FRAMES_PER_RELOAD = RELOAD_FRAMES
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic global_reset_n_i,
    input wire logic standby_n_i,
    input wire logic frame_start_i,
    input wire logic line_start_i,
    input wire logic column_step_i,
    input wire logic fault_i,
    input wire logic serial_data_o,
    input wire logic [$clog2(COLUMNS+1)-1:0] source_column_output_o,
    input wire logic [$clog2(LINES+1)-1:0] gate_line_o,
    input wire settings_t active_settings_o,
    input wire logic nvm_reload_o,
    input wire logic timing_ctrl_en_o,
    input wire logic dac_en_o,
    input wire logic fault_detect_out_o,
    input wire logic fault_detect_out_oe_o
);
    // ****
    // Helper and sequences
    // ****
    logic [3:0] quiet_reg;
    // Cycles since the global reset pin was low, saturating at 8
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            quiet_reg <= 4'h8;
        end else if (!global_reset_n_i) begin
            quiet_reg <= 4'h0;
        end else if (ce_i && quiet_reg != 4'h8) begin
            quiet_reg <= quiet_reg + 4'h1;
        end
    end
    default clocking mon_cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);
    sequence frame_taken;
        frame_start_i && ce_i && quiet_reg == 4'h8;
    endsequence
    sequence step_taken;
        column_step_i && ce_i && !frame_start_i && !line_start_i && quiet_reg == 4'h8;
    endsequence
    sequence standby_held;
        (!standby_n_i && ce_i) [*6];
    endsequence
    sequence greset_held;
        (!global_reset_n_i && ce_i) [*6];
    endsequence
    // ****
    // Assertions
    // ****
    standby_off_a: assert property (standby_held |-> !timing_ctrl_en_o)
        else $error("standby held but timing on");
    fault_follow_a: assert property (
        ce_i |=> fault_detect_out_oe_o == $past(fault_i))
        else $error("fault enable not following fault");
    lines_low_a: assert property (!fault_detect_out_o && !serial_data_o)
        else $error("open drain line driven high");
    column_start_a: assert property (
        frame_taken |=> source_column_output_o == (active_settings_o.hdir_fwd ? 1 : COLUMNS))
        else $error("first column wrong");
    line_start_a: assert property (
        frame_taken |=> gate_line_o == (active_settings_o.vdir_fwd ? 1 : LINES))
        else $error("first line wrong");
    column_step_a: assert property (
        step_taken ##0 source_column_output_o != (active_settings_o.hdir_fwd ? COLUMNS : 1)
        |=> source_column_output_o == (active_settings_o.hdir_fwd
            ? $past(source_column_output_o) + 1 : $past(source_column_output_o) - 1))
        else $error("column step wrong");
    reload_pulse_a: assert property (
        nvm_reload_o |-> $past(frame_start_i) ##1 !nvm_reload_o)
        else $error("reload pulse misplaced");
    reset_values_a: assert property (
        $fell(rst_i) |-> active_settings_o == SETTINGS_RESET && source_column_output_o == 1
            && gate_line_o == 1 && !timing_ctrl_en_o)
        else $error("reset values wrong");
    global_reset_a: assert property (
        greset_held |-> active_settings_o == SETTINGS_RESET && source_column_output_o == 1
            && !dac_en_o)
        else $error("global reset not applied");
endmodule // panel_mode_monitor

bind panel_mode_ctrl panel_mode_monitor #(.COLUMNS(COLUMNS), .LINES(LINES),
    .FRAMES_PER_RELOAD(FRAMES_PER_RELOAD)) u_monitor (.*);
`default_nettype wire

// ==== verif/host_board_model.sv ====
// Host board model working the two-wire configuration bus.
// Data line is pulled up; the device pulls it low through its enable.
`timescale 1ns/1ps
`default_nettype none
module host_board_model (
    input wire logic sys_clk_i,
    input wire logic dev_sda_oe_i,
    output logic scl_o,
    output logic sda_o
);
    // ****
    // Bus levels and transfers
    // ****
    int half = 10; // System clocks per bus phase
    logic sda_drv = 1'b1;
    // Wired-and of both parties on the pulled-up line
    assign sda_o = sda_drv & ~dev_sda_oe_i;
    initial scl_o = 1'b1;
    task automatic wait_phase();
        repeat (half) @(posedge sys_clk_i);
    endtask
    // Data set while clock low, sampled while high
    task automatic bit_slot(input logic b, output logic seen);
        sda_drv <= b;
        wait_phase();
        scl_o <= 1'b1;
        wait_phase();
        seen = sda_o;
        scl_o <= 1'b0;
        wait_phase();
    endtask
    // Start, address and direction, ack, one byte, ack, stop
    task automatic xfer(input logic [6:0] addr, input logic rd, input logic [7:0] wdata,
        output logic [7:0] rdata, output logic ack);
        logic [7:0] head;
        logic s;
        head = {addr, rd};
        sda_drv <= 1'b0;
        wait_phase();
        scl_o <= 1'b0;
        wait_phase();
        for (int i = 7; i >= 0; i--) begin
            bit_slot(head[i], s);
        end
        bit_slot(1'b1, ack);
        for (int i = 7; i >= 0; i--) begin
            bit_slot(rd | wdata[i], rdata[i]);
        end
        bit_slot(1'b1, s);
        sda_drv <= 1'b0;
        wait_phase();
        scl_o <= 1'b1;
        wait_phase();
        sda_drv <= 1'b1;
        wait_phase();
    endtask
endmodule // host_board_model
`default_nettype wire

// ==== verif/testbench.sv ====
// Self-checking bench for the panel mode logic, small geometry.
// Host model works the serial bus; the port monitor is bound in.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import panel_mode_pkg::*;
;
    // ****
    // Signals, instances, helpers
    // ****
    localparam int COLS = 8;
    localparam int LNS = 4;
    localparam int FPR = 3;
    logic sys_clk_i, rst_i, ce_i, global_reset_n_i, standby_n_i, fault_i;
    logic horizontal_scan_dir_i, vertical_scan_dir_i, self_test_en_i;
    logic config_source_select_i, nvm_auto_reload_en_i, polarity_inversion_sel_i;
    logic serial_clk_i, serial_data_i, frame_start_i, line_start_i, column_step_i;
    logic serial_data_o, serial_data_oe_o, nvm_reload_o, timing_ctrl_en_o, dac_en_o;
    logic output_buffer_en_o, power_circuit_en_o, fault_detect_out_o, fault_detect_out_oe_o;
    logic [$clog2(COLS+1)-1:0] source_column_output_o;
    logic [$clog2(LNS+1)-1:0] gate_line_o;
    settings_t active_settings_o;
    int n_fail = 0;
    int checks = 0;
    int cyc = 0;
    int reloads = 0;
    panel_mode_ctrl #(.COLUMNS(COLS), .LINES(LNS), .FRAMES_PER_RELOAD(FPR)) u_dut (.*);
    host_board_model u_host (.sys_clk_i(sys_clk_i), .dev_sda_oe_i(serial_data_oe_o),
        .scl_o(serial_clk_i), .sda_o(serial_data_i));
    initial begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end
    // Cycle ceiling and reload pulse count
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    always @(negedge sys_clk_i) begin
        if (nvm_reload_o === 1'b1) reloads++;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    // One-cycle {frame, line, column} strobe
    task automatic strobe(input logic [2:0] s);
        {frame_start_i, line_start_i, column_step_i} <= s;
        tick(1);
        {frame_start_i, line_start_i, column_step_i} <= 3'h0;
        tick(2);
    endtask
    // Straps {reload, inversion, self test, source, vdir, hdir}
    task automatic set_pins(input logic [5:0] p);
        {nvm_auto_reload_en_i, polarity_inversion_sel_i, self_test_en_i,
            config_source_select_i, vertical_scan_dir_i, horizontal_scan_dir_i} <= p;
        tick(6);
    endtask
    function automatic settings_t exp_pins(input logic [5:0] p);
        return {p[5], p[4], p[3], p[1], p[0]};
    endfunction
    // ****
    // Main sequence
    // ****
    initial begin
        logic [5:0] p;
        settings_t e;
        settings_t prev;
        logic [7:0] d;
        logic [7:0] rd;
        logic ack;
        int unsigned seed;
        {rst_i, ce_i, global_reset_n_i, standby_n_i, fault_i} = 5'h1E;
        {frame_start_i, line_start_i, column_step_i} = 3'h0;
        {nvm_auto_reload_en_i, polarity_inversion_sel_i, self_test_en_i} = 3'h6;
        {config_source_select_i, vertical_scan_dir_i, horizontal_scan_dir_i} = 3'h7;
        seed = $urandom(32'h87C1);
        tick(2);
        check("reset settings", active_settings_o, SETTINGS_RESET);
        rst_i <= 1'b0;
        tick(6);
        prev = SETTINGS_RESET;
        for (int i = 0; i < 8; i++) begin
            p = (i == 0) ? 6'h04 : (6'($urandom()) | 6'h04);
            set_pins(p);
            check("settings before frame", active_settings_o, prev);
            strobe(3'h4);
            e = exp_pins(p);
            check("pin settings", active_settings_o, e);
            check("first column", source_column_output_o, e.hdir_fwd ? 1 : COLS);
            check("first line", gate_line_o, e.vdir_fwd ? 1 : LNS);
            column_step_i <= 1'b1;
            tick(COLS + 1);
            column_step_i <= 1'b0;
            tick(2);
            check("end column", source_column_output_o, e.hdir_fwd ? COLS : 1);
            strobe(3'h2);
            check("next line", gate_line_o, e.vdir_fwd ? 2 : LNS - 1);
            check("restart column", source_column_output_o, e.hdir_fwd ? 1 : COLS);
            prev = e;
        end
        $display("test scan and straps done");
        for (int a = 1; a >= 0; a--) begin
            set_pins({a[0], 5'h07});
            strobe(3'h4);
            reloads = 0;
            repeat (3 * FPR) strobe(3'h4);
            check("reload count", reloads, a ? 3 : 0);
        end
        $display("test reload done");
        set_pins(6'h00);
        for (int i = 0; i < 3; i++) begin
            d = (i == 0) ? 8'hE4 : 8'($urandom());
            u_host.xfer(REG_CTRL, 1'b0, d, rd, ack);
            check("write ack", ack, 1'b0);
            u_host.xfer(REG_CTRL, 1'b1, 8'h00, rd, ack);
            check("ctrl read", rd, {3'h0, d[4:0]});
            strobe(3'h4);
            check("register settings", active_settings_o, d[4:0]);
        end
        u_host.xfer(REG_STATUS, 1'b1, 8'h00, rd, ack);
        check("status read", rd, {3'h2, d[4:0]});
        u_host.half = 24;
        u_host.xfer(7'h05, 1'b1, 8'h00, rd, ack);
        check("unmapped read", rd, RD_UNMAPPED);
        $display("test serial done");
        fault_i <= 1'b1;
        standby_n_i <= 1'b0;
        tick(8);
        check("fault pull", {fault_detect_out_oe_o, fault_detect_out_o}, 2'h2);
        check("standby off", {timing_ctrl_en_o, output_buffer_en_o, dac_en_o,
            power_circuit_en_o}, 4'h0);
        fault_i <= 1'b0;
        standby_n_i <= 1'b1;
        tick(8);
        check("standby on", {timing_ctrl_en_o, dac_en_o, power_circuit_en_o}, 3'h7);
        // Clock enable low freezes the fault register
        ce_i <= 1'b0;
        fault_i <= 1'b1;
        tick(3);
        check("frozen fault", fault_detect_out_oe_o, 1'b0);
        ce_i <= 1'b1;
        fault_i <= 1'b0;
        tick(2);
        global_reset_n_i <= 1'b0;
        tick(6);
        strobe(3'h4);
        check("global reset settings", active_settings_o, SETTINGS_RESET);
        check("global reset power", dac_en_o, 1'b0);
        global_reset_n_i <= 1'b1;
        tick(8);
        u_host.xfer(REG_CTRL, 1'b1, 8'h00, rd, ack);
        check("ctrl after reset", rd, 8'h1B);
        $display("test standby fault reset done");
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire
